/* File: src/dcs_sequencer.v */
// dma channel sequencer: arbitration, fetch, source/destination engines, write-back
// assumes synchronous requests and ready levels, zero-wait read data beside rd_o
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "dcs_defs.vh"
module dcs_sequencer #(
  parameter NCH = 4,
  parameter CHW = 2,
  parameter TIW = 6,
  parameter FDEPTH = 16
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [11:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output reg [31:0] reg_rdata_o,
  input wire [NCH-1:0] drq_i,
  output reg [NCH-1:0] done_o,
  input wire cfg_cpu_hold_i,
  input wire [1:0] seg_busy_i,
  input wire src_rdy_i,
  input wire dst_rdy_i,
  output wire rd_o,
  output wire [15:0] rd_addr_o,
  input wire [31:0] rd_data_i,
  output wire wr_o,
  output wire [15:0] wr_addr_o,
  output wire [7:0] wr_data_o
);
  localparam FCW = 5;

  reg [31:0] cfg0_q [0:NCH-1];
  reg [31:0] basic_q [0:NCH-1];
  reg [7:0] cptr_q [0:NCH-1];
  reg [31:0] wk0_q [0:NCH-1];
  reg [31:0] wk1_q [0:NCH-1];
  reg [31:0] td_mem [0:2*(1<<TIW)-1];
  reg [NCH-1:0] wkv_q;
  reg [NCH-1:0] pend_q;
  reg [NCH-1:0] act_q;
  reg [2:0] st_q;
  reg [1:0] arb_q;
  reg [CHW-1:0] ch_q;
  reg [7:0] ptr_q;
  reg [7:0] nxt_q;
  reg [15:0] cnt_q;
  reg [15:0] src_q;
  reg [15:0] dst_q;
  reg [7:0] w0hi_q;
  reg [7:0] rdl_q;
  reg [7:0] wrl_q;
  reg drain_q;
  reg [31:0] rd_mux;
  integer i;
  genvar g;

  wire [NCH-1:0] cand;
  wire [3*NCH-1:0] prio;
  wire [CHW-1:0] a_idx;
  wire a_val;
  wire a_multi;
  wire [FCW-1:0] fcount;
  wire [7:0] fdout;

  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // a per-burst channel only competes with a fresh request
      assign cand[g] = basic_q[g][`DCS_BASIC_EN] &
        (pend_q[g] | (act_q[g] & ~cfg0_q[g][`DCS_CFG0_PERBURST]));
      assign prio[3*g +: 3] = cfg0_q[g][`DCS_CFG0_PRIO_LSB +: 3];
    end
  endgenerate

  wire grant = (st_q == `DCS_ST_ARB) && (arb_q == 2'h0) && a_val;

  dcs_arbiter #(.NCH(NCH), .CHW(CHW)) u_arb (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .req_i(cand),
    .prio_i(prio),
    .upd_i(grant),
    .gnt_o(a_idx),
    .val_o(a_val),
    .multi_o(a_multi)
  );

  wire [31:0] c0 = cfg0_q[ch_q];
  wire [31:0] cb = basic_q[ch_q];
  wire per_burst = c0[`DCS_CFG0_PERBURST];
  wire restore = cb[`DCS_BASIC_RESTORE];
  wire [7:0] braw = c0[`DCS_CFG0_BURST_LSB +: 8];
  wire [7:0] blen = (braw == 8'h00) ? 8'h01 : braw;
  wire [7:0] bload = (cnt_q < {8'h00, blen}) ? cnt_q[7:0] : blen;
  wire [7:0] fptr = cptr_q[ch_q];
  wire [TIW:0] fidx = {fptr[TIW-1:0], 1'b0};
  wire use_wk = restore & wkv_q[ch_q];
  wire [31:0] f0 = use_wk ? wk0_q[ch_q] : td_mem[fidx];
  wire [31:0] f1 = use_wk ? wk1_q[ch_q] : td_mem[fidx | 1];
  wire preempt = a_val && (prio[3*a_idx +: 3] < c0[`DCS_CFG0_PRIO_LSB +: 3]);

  // segment 0 is 32 bits wide, segment 1 is 16 bits
  wire src_seg = src_q[15];
  wire dst_int = (dst_q[15:12] == `DCS_TD_WIN);
  wire dst_seg = dst_q[15];
  wire same_seg = ~dst_int & (src_seg == dst_seg);
  wire [FCW-1:0] room = FDEPTH[FCW-1:0] - fcount;
  reg [2:0] nb;
  always @* begin
    nb = 3'h1;
    if (!src_seg && src_q[1:0] == 2'h0 && rdl_q >= 8'h04) begin
      nb = 3'h4;
    end else if (src_seg && !src_q[0] && rdl_q >= 8'h02) begin
      nb = 3'h2;
    end
  end
  wire [1:0] lane = src_seg ? {1'b0, src_q[0]} : src_q[1:0];
  wire [31:0] rshift = rd_data_i >> {lane, 3'h0};

  wire rd_ok = (st_q == `DCS_ST_XFER) && (rdl_q != 8'h00) && !seg_busy_i[src_seg] &&
    (room >= {2'h0, nb}) && !(same_seg && drain_q);
  wire rtake = rd_ok & src_rdy_i;
  wire wr_ok = (st_q == `DCS_ST_XFER) && (fcount != {FCW{1'b0}}) &&
    (dst_int || (!seg_busy_i[dst_seg] && (!same_seg || drain_q)));
  wire wtake = wr_ok & (dst_int | dst_rdy_i);
  wire [15:0] nb16 = {13'h0000, nb};

  assign rd_o = rd_ok;
  assign rd_addr_o = src_q;
  assign wr_o = wr_ok & ~dst_int;
  assign wr_addr_o = dst_q;
  assign wr_data_o = fdout;

  dcs_byte_fifo #(.DEPTH(FDEPTH), .CW(FCW)) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .push_n_i(rtake ? nb : 3'h0),
    .din_i(rshift),
    .pop_i(wtake),
    .dout_o(fdout),
    .count_o(fcount)
  );

  // write-back and descriptor completion
  wire in_wb = (st_q == `DCS_ST_WB);
  wire td_done = in_wb && (cnt_q == 16'h0000);
  wire chain_end = td_done && (nxt_q == `DCS_TD_END);
  wire [31:0] wb0 = {w0hi_q, cnt_q, nxt_q};
  wire [31:0] wb1 = {dst_q, src_q};
  wire [CHW-1:0] chain_ch = cb[`DCS_BASIC_CHAIN_LSB +: CHW];
  wire chain_go = chain_end & cb[`DCS_BASIC_CHAIN_EN];
  wire reg_td = reg_addr_i[11];
  wire [3:0] rgn = reg_addr_i[11:8];
  wire [CHW-1:0] rch = reg_addr_i[2 +: CHW];

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (i = 0; i < NCH; i = i + 1) begin
        cfg0_q[i] <= `DCS_CFG0_RST;
        basic_q[i] <= `DCS_BASIC_RST;
      end
    end else if (reg_we_i && !reg_td) begin
      if (rgn == `DCS_RGN_CFG0) begin
        cfg0_q[rch] <= reg_wdata_i;
      end else if (rgn == `DCS_RGN_BASIC) begin
        basic_q[rch] <= reg_wdata_i;
      end
    end
  end

  // descriptor memory: software, engine byte writes and write-back share it
  always @(posedge clk_i) begin
    if (reg_we_i && reg_td) begin
      td_mem[reg_addr_i[TIW+2:2]] <= reg_wdata_i;
    end
    if (wtake && dst_int) begin
      td_mem[dst_q[TIW+2:2]][{dst_q[1:0], 3'h0} +: 8] <= fdout;
    end
    if (in_wb && !restore) begin
      td_mem[fidx] <= wb0;
      td_mem[fidx | 1] <= wb1;
    end
  end

  // separate processing area; the original stays reusable
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wkv_q <= {NCH{1'b0}};
    end else if (in_wb && restore) begin
      wkv_q[ch_q] <= ~td_done;
    end
  end

  always @(posedge clk_i) begin
    if (in_wb && restore) begin
      wk0_q[ch_q] <= wb0;
      wk1_q[ch_q] <= wb1;
    end
  end

  // request flags: a new request in the grant cycle is kept
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_q <= {NCH{1'b0}};
      act_q <= {NCH{1'b0}};
      done_o <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        cptr_q[i] <= 8'h00;
      end
    end else begin
      done_o <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        if (drq_i[i] || (chain_go && chain_ch == i[CHW-1:0])) begin
          pend_q[i] <= 1'b1;
        end else if (grant && a_idx == i[CHW-1:0]) begin
          pend_q[i] <= 1'b0;
        end
        // disabling a per-burst channel between descriptors lets software restart an endless ring at a new start index
        if (!basic_q[i][`DCS_BASIC_EN]) begin
          act_q[i] <= 1'b0;
        end
      end
      if (grant) begin
        act_q[a_idx] <= 1'b1;
        if (!act_q[a_idx]) begin
          cptr_q[a_idx] <= cfg0_q[a_idx][`DCS_CFG0_START_LSB +: 8];
        end
      end
      if (td_done) begin
        cptr_q[ch_q] <= nxt_q;
      end
      if (chain_end) begin
        act_q[ch_q] <= 1'b0;
        done_o[ch_q] <= 1'b1;
      end
    end
  end

  // engine phases
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= `DCS_ST_IDLE;
      arb_q <= 2'h0;
      ch_q <= {CHW{1'b0}};
      ptr_q <= 8'h00;
      nxt_q <= 8'h00;
      cnt_q <= 16'h0000;
      src_q <= 16'h0000;
      dst_q <= 16'h0000;
      w0hi_q <= 8'h00;
      rdl_q <= 8'h00;
      wrl_q <= 8'h00;
      drain_q <= 1'b0;
    end else begin
      case (st_q)
        `DCS_ST_IDLE: begin
          if (cand != {NCH{1'b0}}) begin
            st_q <= `DCS_ST_ARB;
            arb_q <= (a_multi ? `DCS_ARB_MULTI : `DCS_ARB_SINGLE) - 2'h1;
          end
        end
        `DCS_ST_ARB: begin
          if (arb_q != 2'h0) begin
            arb_q <= arb_q - 2'h1;
          end else if (a_val) begin
            ch_q <= a_idx;
            st_q <= `DCS_ST_FETCH;
          end else begin
            st_q <= `DCS_ST_IDLE;
          end
        end
        `DCS_ST_FETCH: begin
          if (!cfg_cpu_hold_i) begin
            ptr_q <= fptr;
            nxt_q <= f0[`DCS_TD0_NEXT_LSB +: 8];
            cnt_q <= f0[`DCS_TD0_CNT_LSB +: 16];
            w0hi_q <= f0[31:24];
            src_q <= f1[15:0];
            dst_q <= f1[31:16];
            drain_q <= 1'b0;
            st_q <= `DCS_ST_XFER;
            if (f0[`DCS_TD0_CNT_LSB +: 16] < {8'h00, blen}) begin
              rdl_q <= f0[`DCS_TD0_CNT_LSB +: 8];
              wrl_q <= f0[`DCS_TD0_CNT_LSB +: 8];
            end else begin
              rdl_q <= blen;
              wrl_q <= blen;
            end
          end
        end
        `DCS_ST_XFER: begin
          if (rtake) begin
            rdl_q <= rdl_q - {5'h00, nb};
            if (w0hi_q[`DCS_TD0_INCS - 24]) begin
              src_q <= src_q + nb16;
            end
          end
          if (wtake) begin
            wrl_q <= wrl_q - 8'h01;
            cnt_q <= cnt_q - 16'h0001;
            if (w0hi_q[`DCS_TD0_INCD - 24]) begin
              dst_q <= dst_q + 16'h0001;
            end
          end
          // same segment: fill until room runs short, then empty completely
          if (fcount == {FCW{1'b0}} && rdl_q != 8'h00) begin
            drain_q <= 1'b0;
          end else if (room < {2'h0, nb} || rdl_q == 8'h00) begin
            drain_q <= 1'b1;
          end
          if (wrl_q == 8'h00) begin
            st_q <= `DCS_ST_WB;
          end
        end
        `DCS_ST_WB: begin
          drain_q <= 1'b0;
          if (chain_end || per_burst || preempt) begin
            st_q <= `DCS_ST_IDLE;
          end else if (td_done) begin
            st_q <= `DCS_ST_FETCH;
          end else begin
            rdl_q <= bload;
            wrl_q <= bload;
            st_q <= `DCS_ST_XFER;
          end
        end
        default: begin
          st_q <= `DCS_ST_IDLE;
        end
      endcase
    end
  end

  // register read, answered one cycle after the strobe
  always @* begin
    rd_mux = 32'h0000_0000;
    if (reg_td) begin
      rd_mux = td_mem[reg_addr_i[TIW+2:2]];
    end else if (rgn == `DCS_RGN_CFG0) begin
      rd_mux = cfg0_q[rch];
    end else if (rgn == `DCS_RGN_BASIC) begin
      rd_mux = basic_q[rch];
    end else if (rgn == `DCS_RGN_STAT) begin
      rd_mux = {20'h00000, wkv_q[rch], act_q[rch], pend_q[rch], 1'b0, cptr_q[rch]};
    end else if (rgn == `DCS_RGN_GLOB) begin
      rd_mux = {ptr_q, 3'h0, fcount, {(8-CHW){1'b0}}, ch_q, 5'h00, st_q};
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_re_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end
endmodule

/* File: common/dcs_defs.vh */
// constants of the dma channel sequencer: register map, field positions, phase counts
// assumes inclusion by bare name from the design files
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH

// register regions, selected by address bits [11:8]; address bit 11 selects descriptors
`define DCS_RGN_CFG0 4'h0
`define DCS_RGN_BASIC 4'h1
`define DCS_RGN_STAT 4'h2
`define DCS_RGN_GLOB 4'h3

// channel_config_word0 fields
`define DCS_CFG0_PRIO_LSB 0
`define DCS_CFG0_PERBURST 7
`define DCS_CFG0_BURST_LSB 8
`define DCS_CFG0_START_LSB 16
`define DCS_CFG0_RST 32'h0000_0107

// channel_basic_config fields
`define DCS_BASIC_EN 0
`define DCS_BASIC_CHAIN_EN 6
`define DCS_BASIC_RESTORE 5
`define DCS_BASIC_CHAIN_LSB 8
`define DCS_BASIC_RST 32'h0000_0000

// descriptor_word0 fields
`define DCS_TD0_NEXT_LSB 0
`define DCS_TD0_CNT_LSB 8
`define DCS_TD0_INCS 24
`define DCS_TD0_INCD 25
`define DCS_TD_END 8'hff

// destination window that maps onto descriptor memory
`define DCS_TD_WIN 4'hf

// arbitration phase length in cycles
`define DCS_ARB_SINGLE 2'h1
`define DCS_ARB_MULTI 2'h2

// engine states
`define DCS_ST_IDLE 3'h0
`define DCS_ST_ARB 3'h1
`define DCS_ST_FETCH 3'h2
`define DCS_ST_XFER 3'h3
`define DCS_ST_WB 3'h4

`endif

/* File: src/dcs_byte_fifo.v */
// byte fifo between source and destination engines; takes up to four bytes per cycle
// assumes the writer never pushes more than the free room and never pops when empty
`timescale 1ns/1ps
module dcs_byte_fifo #(
  parameter DEPTH = 16,
  parameter CW = 5
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [2:0] push_n_i,
  input wire [31:0] din_i,
  input wire pop_i,
  output wire [7:0] dout_o,
  output reg [CW-1:0] count_o
);
  reg [7:0] mem [0:DEPTH-1];
  reg [CW-2:0] wp_q;
  reg [CW-2:0] rp_q;
  integer k;

  assign dout_o = mem[rp_q];

  always @(posedge clk_i) begin
    for (k = 0; k < 4; k = k + 1) begin
      if (k < push_n_i) begin
        mem[wp_q + k[CW-2:0]] <= din_i[8*k +: 8];
      end
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_q <= {(CW-1){1'b0}};
      rp_q <= {(CW-1){1'b0}};
      count_o <= {CW{1'b0}};
    end else begin
      wp_q <= wp_q + {{(CW-4){1'b0}}, push_n_i};
      if (pop_i) begin
        rp_q <= rp_q + {{(CW-2){1'b0}}, 1'b1};
      end
      count_o <= count_o + {{(CW-3){1'b0}}, push_n_i} - {{(CW-1){1'b0}}, pop_i};
    end
  end
endmodule

/* File: src/dcs_arbiter.v */
// channel arbiter: lowest priority value wins, then least recently served, then lowest index
// assumes upd_i pulses for one cycle when the winner is granted
`timescale 1ns/1ps
module dcs_arbiter #(
  parameter NCH = 4,
  parameter CHW = 2
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire [NCH-1:0] req_i,
  input wire [3*NCH-1:0] prio_i,
  input wire upd_i,
  output reg [CHW-1:0] gnt_o,
  output reg val_o,
  output wire multi_o
);
  reg [7:0] age_q [0:NCH-1];
  reg [2:0] bp;
  reg [7:0] ba;
  integer i;
  genvar g;

  // saturating age: grows while others are served, clears when served
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_age
      localparam [CHW-1:0] GI = g;
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          age_q[g] <= 8'h00;
        end else if (upd_i) begin
          if (gnt_o == GI) begin
            age_q[g] <= 8'h00;
          end else if (age_q[g] != 8'hff) begin
            age_q[g] <= age_q[g] + 8'h01;
          end
        end
      end
    end
  endgenerate

  assign multi_o = (req_i & (req_i - {{(NCH-1){1'b0}}, 1'b1})) != {NCH{1'b0}};

  always @* begin
    gnt_o = {CHW{1'b0}};
    val_o = 1'b0;
    bp = 3'h7;
    ba = 8'h00;
    for (i = 0; i < NCH; i = i + 1) begin
      // strict compares keep the lower index on a full tie
      if (req_i[i] && (!val_o || prio_i[3*i +: 3] < bp ||
          (prio_i[3*i +: 3] == bp && age_q[i] > ba))) begin
        val_o = 1'b1;
        gnt_o = i[CHW-1:0];
        bp = prio_i[3*i +: 3];
        ba = age_q[i];
      end
    end
  end
endmodule

/* File: dv/dcs_monitor.sv */
// port checker of the dma channel sequencer
// assumes one clock domain; bound to every dcs_sequencer instance
`timescale 1ns/1ps
module dcs_monitor #(
  parameter NCH = 4
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire reg_re_i,
  input wire [31:0] reg_rdata_o,
  input wire [NCH-1:0] done_o,
  input wire [1:0] seg_busy_i,
  input wire src_rdy_i,
  input wire dst_rdy_i,
  input wire rd_o,
  input wire [15:0] rd_addr_o,
  input wire wr_o,
  input wire [15:0] wr_addr_o,
  input wire [7:0] wr_data_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_rd_seg_free: assert property (rd_o |-> !seg_busy_i[rd_addr_o[15]])
    else $error("read on an occupied segment");
  a_wr_seg_free: assert property (wr_o |-> !seg_busy_i[wr_addr_o[15]])
    else $error("write on an occupied segment");
  a_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  a_done_pulse: assert property (|done_o |=> done_o == '0)
    else $error("done longer than one cycle");
  a_done_quiet: assert property (|done_o |-> !rd_o && !wr_o && !$past(wr_o))
    else $error("done without a write-back gap");
  a_rd_wait_hold: assert property (rd_o && !src_rdy_i |=> $stable(rd_addr_o))
    else $error("read address moved while source waits");
  a_wr_wait_hold: assert property (wr_o && !dst_rdy_i |=>
    $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write moved while destination waits");
  a_same_seg_serial: assert property (rd_o && wr_o |->
    rd_addr_o[15] != wr_addr_o[15])
    else $error("fill and drain overlap on one segment");
endmodule

bind dcs_sequencer dcs_monitor #(.NCH(NCH)) mon (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .done_o(done_o), .seg_busy_i(seg_busy_i), .src_rdy_i(src_rdy_i), .dst_rdy_i(dst_rdy_i),
  .rd_o(rd_o), .rd_addr_o(rd_addr_o), .wr_o(wr_o), .wr_addr_o(wr_addr_o),
  .wr_data_o(wr_data_o));

/* File: dv/dcs_far_mem.sv */
// far side: byte memory and peripherals behind both segments
// assumes ready levels come from the bench; reads answer with no wait
`timescale 1ns/1ps
module dcs_far_mem (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [15:0] rd_addr_i,
  output logic [31:0] rd_data_o,
  input wire logic wr_i,
  input wire logic dst_rdy_i,
  input wire logic [15:0] wr_addr_i,
  input wire logic [7:0] wr_data_i
);
  logic [7:0] mem [0:65535];
  logic [31:0] junk = 32'h5a5a_a5a5;
  logic [15:0] a;
  // idle bus shows a moving pattern so stale data never passes
  always_comb begin
    a = rd_addr_i & (rd_addr_i[15] ? 16'hfffe : 16'hfffc);
    rd_data_o = junk;
    if (rd_i) rd_data_o = {mem[a + 16'h3], mem[a + 16'h2], mem[a + 16'h1], mem[a]};
  end
  always @(posedge clk_i) begin
    junk <= ~{junk[30:0], junk[31]};
    if (wr_i && dst_rdy_i) mem[wr_addr_i] <= wr_data_i;
  end
endmodule

/* File: dv/tb_top.sv */
// self-checking bench of the dma channel sequencer
// assumes the far model holds memory; ready lines patterned here
`timescale 1ns/1ps
`include "dcs_defs.vh"
module tb_top;
  logic clk_i = 0, rst_b_i = 0, reg_we_i = 0, reg_re_i = 0, cfg_cpu_hold_i = 0;
  logic src_rdy_i = 1, dst_rdy_i = 1, slow = 0, rd_o, wr_o;
  logic [11:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, rd_data_i, q;
  logic [3:0] drq_i = 0, done_o;
  logic [1:0] seg_busy_i = 0;
  logic [15:0] rd_addr_o, wr_addr_o;
  logic [7:0] wr_data_o;
  logic [7:0] got_q[$], exp_q[$];
  int mismatches = 0, compares = 0, nrd = 0, cyc = 0, n0, t1, t2, t3;

  dcs_sequencer DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .drq_i(drq_i), .done_o(done_o),
    .cfg_cpu_hold_i(cfg_cpu_hold_i), .seg_busy_i(seg_busy_i), .src_rdy_i(src_rdy_i),
    .dst_rdy_i(dst_rdy_i), .rd_o(rd_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
    .wr_o(wr_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
  dcs_far_mem far (.clk_i(clk_i), .rd_i(rd_o), .rd_addr_i(rd_addr_o),
    .rd_data_o(rd_data_i), .wr_i(wr_o), .dst_rdy_i(dst_rdy_i),
    .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o));

  initial forever #12.5 clk_i = ~clk_i;

  // stalls come from a fixed pattern so both peripherals lag unevenly
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    src_rdy_i <= !slow || cyc[0];
    dst_rdy_i <= !slow || (cyc % 3 == 0);
    if (wr_o === 1'b1 && dst_rdy_i === 1'b1) got_q.push_back(wr_data_o);
    if (rd_o === 1'b1 && src_rdy_i === 1'b1) nrd <= nrd + 1;
  end

  task automatic bad(input string m);
    mismatches++;
    $display("mismatch t=%0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) bad($sformatf("word %h exp %h", g, e));
  endtask
  task automatic chk_bytes();
    compares++;
    if (got_q.size() != exp_q.size()) bad($sformatf("%0d bytes", got_q.size()));
    else foreach (exp_q[i]) if (got_q[i] !== exp_q[i]) bad($sformatf("byte %0d", i));
    got_q.delete();
    exp_q.delete();
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= w;
    reg_re_i <= !w;
    @(posedge clk_i);
    reg_we_i <= 0;
    reg_re_i <= 0;
    #1 q = reg_rdata_o;
  endtask
  task automatic cfg(input int c, input logic [31:0] w0, input logic [31:0] b);
    bus(1, 12'(4 * c), w0);
    bus(1, 12'(12'h100 + 4 * c), b);
  endtask
  task automatic wd(input int i, input int nx, input int n, input logic [15:0] s,
                    input logic [15:0] d);
    bus(1, 12'(12'h800 + 8 * i), {6'h0, 2'b11, 16'(n), 8'(nx)});
    bus(1, 12'(12'h804 + 8 * i), {d, s});
  endtask
  task automatic fill(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++) far.mem[16'(a + i)] = 8'($urandom);
  endtask
  task automatic want(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(far.mem[16'(a + i)]);
  endtask
  task automatic go(input int ch);
    @(posedge clk_i);
    drq_i[ch] <= 1;
    @(posedge clk_i);
    drq_i <= 0;
    repeat (600) begin
      @(posedge clk_i);
      if (got_q.size() >= exp_q.size()) break;
    end
    repeat (30) @(posedge clk_i);
    chk_bytes();
  endtask
  // per-burst descriptor ring, two bursts per descriptor, one per request
  task automatic ring(input int f, input int len);
    for (int k = 0; k < len; k++) begin
      wd(f + k, (k == len - 1) ? f : f + k + 1, 4, 16'(16'h00a0 + 8 * k), 16'h8300);
      fill(16'(16'h00a0 + 8 * k), 4);
    end
    bus(1, 12'h100, 0);
    cfg(0, {8'h0, 8'(f), 16'h0280}, 32'h21);
    for (int r = 0; r < 2 * len + 2; r++) begin
      want(16'(16'h00a0 + 8 * ((r / 2) % len) + 2 * (r % 2)), 2);
      go(0);
    end
  endtask
  // cycles from request to first read; cpu hold and segment busy from the request
  task automatic lat(input logic [3:0] m, input int h, input int b, output int t);
    @(posedge clk_i);
    drq_i <= m;
    cfg_cpu_hold_i <= h > 0;
    seg_busy_i <= {1'b0, b > 0};
    for (t = 1; t < 200; t++) begin
      @(posedge clk_i);
      drq_i <= 0;
      if (t == h) cfg_cpu_hold_i <= 0;
      if (t == b) seg_busy_i <= 0;
      #1;
      if (rd_o === 1'b1) break;
    end
    q = {16'h0, rd_addr_o};
    repeat (80) @(posedge clk_i);
    got_q.delete();
    exp_q.delete();
  endtask
  task automatic print_verdict();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #500000;
    bad("watchdog expired");
    print_verdict();
  end

  initial begin
    q = $urandom(38570);
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1;
    for (int c = 0; c < 4; c++) begin
      bus(0, 12'(4 * c), 0);
      chk(q, `DCS_CFG0_RST);
      bus(0, 12'(12'h100 + 4 * c), 0);
      chk(q, `DCS_BASIC_RST);
    end
    bus(1, 12'h400, 32'hffff_ffff);
    bus(0, 12'h400, 0);
    chk(q, 32'h0);
    // aligned copy, descriptor kept in its final state
    wd(0, 8'hff, 4, 16'h0000, 16'h8000);
    cfg(0, 32'h0000_0400, 32'h1);
    fill(16'h0000, 4);
    want(16'h0000, 4);
    n0 = nrd;
    go(0);
    chk(nrd - n0, 1);
    bus(0, 12'h800, 0);
    chk(q, 32'h0300_00ff);
    bus(0, 12'h804, 0);
    chk(q, 32'h8004_0004);
    // misaligned source with both peripherals stalling, restore on
    slow = 1;
    wd(1, 8'hff, 7, 16'h0011, 16'h8010);
    cfg(1, 32'h0001_0800, 32'h21);
    fill(16'h0011, 7);
    want(16'h0011, 7);
    n0 = nrd;
    go(1);
    slow = 0;
    chk(nrd - n0, 4);
    bus(0, 12'h808, 0);
    chk(q, 32'h0300_07ff);
    bus(0, 12'h80c, 0);
    chk(q, 32'h8010_0011);
    // gather two pieces into one block on the same segment
    wd(2, 3, 6, 16'h0040, 16'h0100);
    wd(3, 8'hff, 5, 16'h0081, 16'h0106);
    cfg(2, 32'h0002_1000, 32'h1);
    fill(16'h0040, 6);
    fill(16'h0081, 5);
    want(16'h0040, 6);
    want(16'h0081, 5);
    go(2);
    // address fetch rewrites the next descriptor, then chains a channel
    far.mem[16'h0020] = 8'h60;
    far.mem[16'h0021] = 8'h00;
    wd(4, 5, 2, 16'h0020, 16'hf02c);
    wd(5, 8'hff, 3, 16'h0000, 16'h8200);
    wd(24, 8'hff, 2, 16'h00c0, 16'h8400);
    cfg(2, 32'h0018_0100, 32'h21);
    cfg(3, 32'h0004_0800, 32'h241);
    fill(16'h0060, 3);
    fill(16'h00c0, 2);
    want(16'h0060, 3);
    want(16'h00c0, 2);
    go(3);
    ring(8, 1);
    ring(12, 2);
    ring(16, 3);
    lat(4'b0010, 0, 0, t1);
    lat(4'b0110, 0, 0, t2);
    chk(t2 - t1, 1);
    chk(q, 32'h0000_00c0);
    lat(4'b0010, 4, 0, t1);
    lat(4'b0010, 6, 0, t2);
    chk(t2 - t1, 2);
    lat(4'b0010, 0, 5, t1);
    lat(4'b0010, 0, 8, t3);
    chk(t3 - t1, 3);
    print_verdict();
  end
endmodule
